// >>> rtl/rsf_reset_flags.sv
// Reset cause flag register, device reset on flash key, watchdog flags
//
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Flag register bits 7..4 read zero
// - Low supply reset sets bit 2
// - Low supply flag cleared only by software zero
// - Key 55H in flash control resets device
// - Normal watchdog timeout sets timeout flag
// - Sleep watchdog timeout keeps most state
// - Sleep watchdog timeout clears PC and SP
// - Sleep watchdog timeout sets timeout, powerdown flags
// - Bad threshold code sets bit 1
// - Guard register reset sets bit 3, software clears
module rsf_reset_flags (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [rsf_pkg::ADDR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Reset source events, one-cycle pulses
	input wire logic low_supply_rst_i,
	input wire logic thresh_corrupt_rst_i,
	input wire logic guard_reg_rst_i,
	input wire logic wdt_cfg_rst_i,
	input wire logic wdt_timeout_i,
	input wire logic low_power_i,
	// Reset outputs
	output logic dev_reset_o,
	output logic warm_reset_o,
	output logic watchdog_timeout_flag_o,
	output logic powerdown_flag_o,
	// Interrupt
	output logic irq_o
);
	logic wr;
	logic rd;
	logic ack_d;
	logic [rsf_pkg::FLAG_W-1:0] reset_cause_flags_q;
	logic [rsf_pkg::FLAG_W-1:0] reset_cause_flags_d;
	logic [rsf_pkg::FLAG_W-1:0] hw_set;
	logic [rsf_pkg::EV_W-1:0] ev_set;
	logic [rsf_pkg::EV_W-1:0] ev_clr;
	logic [rsf_pkg::EV_W-1:0] ev_flags;
	logic [rsf_pkg::EV_W-1:0] irq_mask_q;
	logic [7:0] flash_ctrl_one_q;
	logic flash_key_hit;
	logic [2:0] dev_rst_cnt_q;
	logic dev_reset_q;
	logic warm_reset_q;
	logic wdt_to_q;
	logic pdf_q;
	logic irq_d;
	logic irq_q;
	logic [31:0] dat_q;
	logic [31:0] rd_d;

	rsf_wb_slave #(
		.AW(rsf_pkg::ADDR_W)
	) u_bus (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cyc_i(cyc_i),
		.stb_i(stb_i),
		.we_i(we_i),
		.ack_q_i(ack_o),
		.wr_o(wr),
		.rd_o(rd),
		.ack_d_o(ack_d)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= ack_d;
		end
	end

	// Hardware events set the cause flags
	always_comb begin
		hw_set = '0;
		hw_set[rsf_pkg::BIT_LOW_SUPPLY] = low_supply_rst_i;
		hw_set[rsf_pkg::BIT_THRESH] = thresh_corrupt_rst_i;
		hw_set[rsf_pkg::BIT_GUARD] = guard_reg_rst_i;
		hw_set[rsf_pkg::BIT_WDT_CFG] = wdt_cfg_rst_i;
	end

	// Software writes only clear; a write of one keeps the flag as is
	always_comb begin
		reset_cause_flags_d = reset_cause_flags_q;
		if (wr && adr_i == rsf_pkg::OFF_FLAGS && sel_i[0]) begin
			reset_cause_flags_d = reset_cause_flags_q &
				dat_i[rsf_pkg::FLAG_W-1:0];
		end
		reset_cause_flags_d = reset_cause_flags_d | hw_set;
	end

	// Flags live across the device resets this block issues
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reset_cause_flags_q <= rsf_pkg::FLAGS_RST;
		end else begin
			reset_cause_flags_q <= reset_cause_flags_d;
		end
	end

	// Flash control register and key detection
	assign flash_key_hit = wr && adr_i == rsf_pkg::OFF_FLASH_CTRL &&
		sel_i[0] && dat_i[7:0] == rsf_pkg::FLASH_RESET_KEY;

	always_ff @(posedge clk_i) begin
		if (rst_i || dev_reset_q) begin
			flash_ctrl_one_q <= rsf_pkg::FLASH_CTRL_RST;
		end else if (wr && adr_i == rsf_pkg::OFF_FLASH_CTRL && sel_i[0]) begin
			flash_ctrl_one_q <= dat_i[7:0];
		end
	end

	// Whole-device reset pulse of fixed length
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dev_reset_q <= 1'b0;
			dev_rst_cnt_q <= 3'h0;
		end else if (flash_key_hit && !dev_reset_q) begin
			dev_reset_q <= 1'b1;
			dev_rst_cnt_q <= 3'h0;
		end else if (dev_reset_q) begin
			if (dev_rst_cnt_q == rsf_pkg::DEV_RST_LAST) begin
				dev_reset_q <= 1'b0;
			end
			dev_rst_cnt_q <= dev_rst_cnt_q + 3'h1;
		end
	end

	// Watchdog timeout: flag only (no reset) when awake, warm restart asleep
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wdt_to_q <= 1'b0;
			pdf_q <= 1'b0;
			warm_reset_q <= 1'b0;
		end else begin
			warm_reset_q <= wdt_timeout_i && low_power_i;
			if (wdt_timeout_i) begin
				wdt_to_q <= 1'b1;
				if (low_power_i) begin
					pdf_q <= 1'b1;
				end
			end
		end
	end

	// Only PC and SP clear on warm reset; the core keeps the rest
	assign warm_reset_o = warm_reset_q;
	assign dev_reset_o = dev_reset_q;
	assign watchdog_timeout_flag_o = wdt_to_q;
	assign powerdown_flag_o = pdf_q;

	// Interrupt status, set wins over write-one-to-clear
	always_comb begin
		ev_set = '0;
		ev_set[rsf_pkg::EV_WDT_CFG] = wdt_cfg_rst_i;
		ev_set[rsf_pkg::EV_THRESH] = thresh_corrupt_rst_i;
		ev_set[rsf_pkg::EV_LOW_SUPPLY] = low_supply_rst_i;
		ev_set[rsf_pkg::EV_GUARD] = guard_reg_rst_i;
		ev_set[rsf_pkg::EV_WDT_TO] = wdt_timeout_i;
		ev_set[rsf_pkg::EV_FLASH_KEY] = flash_key_hit;
		ev_clr = '0;
		if (wr && adr_i == rsf_pkg::OFF_IRQ_STAT && sel_i[0]) begin
			ev_clr = dat_i[rsf_pkg::EV_W-1:0];
		end
	end

	rsf_event_flags #(
		.W(rsf_pkg::EV_W)
	) u_events (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.set_i(ev_set),
		.clr_i(ev_clr),
		.mask_i(irq_mask_q),
		.flags_o(ev_flags),
		.irq_o(irq_d)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_mask_q <= rsf_pkg::EV_RST;
		end else if (wr && adr_i == rsf_pkg::OFF_IRQ_MASK && sel_i[0]) begin
			irq_mask_q <= dat_i[rsf_pkg::EV_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end
	assign irq_o = irq_q;

	// Read mux; unmapped offsets read zero
	always_comb begin
		rd_d = 32'h0000_0000;
		unique case (adr_i)
			rsf_pkg::OFF_FLAGS: rd_d[rsf_pkg::FLAG_W-1:0] =
				reset_cause_flags_q;
			rsf_pkg::OFF_IRQ_STAT: rd_d[rsf_pkg::EV_W-1:0] = ev_flags;
			rsf_pkg::OFF_IRQ_MASK: rd_d[rsf_pkg::EV_W-1:0] = irq_mask_q;
			rsf_pkg::OFF_FLASH_CTRL: rd_d[7:0] = flash_ctrl_one_q;
			default: rd_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_q <= 32'h0000_0000;
		end else if (rd) begin
			dat_q <= rd_d;
		end
	end
	assign dat_o = dat_q;
endmodule
`default_nettype wire

// >>> shared/rsf_pkg.sv
// Package for the reset cause flag block: offsets, fields, reset values
package rsf_pkg;
	localparam int unsigned ADDR_W = 4;
	// Register word byte offsets
	localparam logic [ADDR_W-1:0] OFF_FLAGS = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'h8;
	localparam logic [ADDR_W-1:0] OFF_FLASH_CTRL = 4'hC;
	// Flag bit positions
	localparam int unsigned BIT_WDT_CFG = 0;
	localparam int unsigned BIT_THRESH = 1;
	localparam int unsigned BIT_LOW_SUPPLY = 2;
	localparam int unsigned BIT_GUARD = 3;
	localparam int unsigned FLAG_W = 4;
	// Interrupt event bit positions
	localparam int unsigned EV_WDT_CFG = 0;
	localparam int unsigned EV_THRESH = 1;
	localparam int unsigned EV_LOW_SUPPLY = 2;
	localparam int unsigned EV_GUARD = 3;
	localparam int unsigned EV_WDT_TO = 4;
	localparam int unsigned EV_FLASH_KEY = 5;
	localparam int unsigned EV_W = 6;
	// Reset values
	localparam logic [FLAG_W-1:0] FLAGS_RST = 4'h0;
	localparam logic [EV_W-1:0] EV_RST = 6'h00;
	localparam logic [7:0] FLASH_CTRL_RST = 8'h00;
	localparam logic [7:0] FLASH_RESET_KEY = 8'h55;
	// Length of the generated whole-device reset pulse, in cycles
	localparam int unsigned DEV_RST_CYCLES = 4;
	localparam logic [2:0] DEV_RST_LAST = 3'(DEV_RST_CYCLES - 1);
endpackage

// >>> rtl/rsf_event_flags.sv
// Sticky event flags: hardware set wins over write-one-to-clear
`timescale 1ns/1ps
`default_nettype none
module rsf_event_flags #(
	parameter int unsigned W = 6
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Events and clearing
	input wire logic [W-1:0] set_i,
	input wire logic [W-1:0] clr_i,
	input wire logic [W-1:0] mask_i,
	// State
	output logic [W-1:0] flags_o,
	output logic irq_o
);
	logic [W-1:0] flags_q;

	for (genvar i = 0; i < W; i++) begin : g_flag
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				flags_q[i] <= 1'b0;
			end else if (set_i[i]) begin
				flags_q[i] <= 1'b1;
			end else if (clr_i[i]) begin
				flags_q[i] <= 1'b0;
			end
		end
	end

	assign flags_o = flags_q;
	assign irq_o = |(flags_q & mask_i);
endmodule
`default_nettype wire

// >>> rtl/rsf_wb_slave.sv
// Classic Wishbone decode: one-cycle ack, strobes for write and read
`timescale 1ns/1ps
`default_nettype none
module rsf_wb_slave #(
	parameter int unsigned AW = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone request
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic ack_q_i,
	// Strobes
	output logic wr_o,
	output logic rd_o,
	output logic ack_d_o
);
	// Answer one cycle after the request, never twice back to back
	logic req;
	assign req = cyc_i && stb_i && !ack_q_i && !rst_i;
	assign ack_d_o = req;
	assign wr_o = req && we_i;
	assign rd_o = req && !we_i;
endmodule
`default_nettype wire

// >>> sim/rsf_reset_flags_assertions.sv
// Checker for the reset cause flag block, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module rsf_reset_flags_assertions (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [rsf_pkg::ADDR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// Watchdog and resets
	input wire logic wdt_timeout_i,
	input wire logic low_power_i,
	input wire logic dev_reset_o,
	input wire logic warm_reset_o,
	input wire logic watchdog_timeout_flag_o,
	input wire logic powerdown_flag_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic req;
	logic key;
	logic slp;
	assign req = cyc_i && stb_i && !ack_o;
	assign key = req && we_i && sel_i[0] &&
		adr_i == rsf_pkg::OFF_FLASH_CTRL &&
		dat_i[7:0] == rsf_pkg::FLASH_RESET_KEY;
	assign slp = wdt_timeout_i && low_power_i;
	ack_pulse_a: assert property (req |=> ack_o ##1 !ack_o)
		else $error("ack not one cycle after request");
	upper_zero_a: assert property (
		ack_o && !we_i && adr_i == rsf_pkg::OFF_FLAGS |-> dat_o[31:4] == 28'h0)
		else $error("flag read upper bits not zero");
	key_reset_a: assert property (
		key && !dev_reset_o |=> dev_reset_o [*4] ##1 !dev_reset_o)
		else $error("device reset pulse wrong after key");
	reset_cause_a: assert property ($rose(dev_reset_o) |-> $past(key))
		else $error("device reset without key write");
	wdt_flag_a: assert property (wdt_timeout_i |=> watchdog_timeout_flag_o)
		else $error("timeout flag not set");
	pd_keep_a: assert property (
		wdt_timeout_i && !low_power_i |=> $stable(powerdown_flag_o))
		else $error("powerdown flag moved on normal timeout");
	sleep_wake_a: assert property (
		slp |=> powerdown_flag_o && warm_reset_o && !dev_reset_o)
		else $error("sleep timeout response wrong");
	warm_cause_a: assert property (!slp |=> !warm_reset_o)
		else $error("warm reset without sleep timeout");
	cover property (key);
	cover property (slp);
	cover property (ack_o && !we_i);
endmodule
bind rsf_reset_flags rsf_reset_flags_assertions rsf_reset_flags_assertions_inst (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.wdt_timeout_i(wdt_timeout_i), .low_power_i(low_power_i),
	.dev_reset_o(dev_reset_o), .warm_reset_o(warm_reset_o),
	.watchdog_timeout_flag_o(watchdog_timeout_flag_o),
	.powerdown_flag_o(powerdown_flag_o));
`default_nettype wire

// >>> sim/tb_rsf_reset_flags.sv
// Self-checking bench for the reset cause flag block
`timescale 1ns/1ps
`default_nettype none
module tb_rsf_reset_flags;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, wd = 0, lp = 0;
	logic [3:0] adr = 4'h0, sel = 4'h0, ev = 4'h0;
	logic [31:0] dat = 32'h0, dat_o, q;
	logic ack_o, dev_o, warm_o, to_o, pd_o, irq_o;
	int fails = 0, n_tests = 0, n_dev = 0, n_warm = 0;
	rsf_reset_flags rsf_reset_flags_inst (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
		.dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
		.low_supply_rst_i(ev[rsf_pkg::BIT_LOW_SUPPLY]),
		.thresh_corrupt_rst_i(ev[rsf_pkg::BIT_THRESH]),
		.guard_reg_rst_i(ev[rsf_pkg::BIT_GUARD]),
		.wdt_cfg_rst_i(ev[rsf_pkg::BIT_WDT_CFG]), .wdt_timeout_i(wd),
		.low_power_i(lp), .dev_reset_o(dev_o), .warm_reset_o(warm_o),
		.watchdog_timeout_flag_o(to_o), .powerdown_flag_o(pd_o),
		.irq_o(irq_o));
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	// Pulse widths counted apart from the scenarios
	always @(posedge clk_i) begin
		n_dev += (dev_o === 1'b1);
		n_warm += (warm_o === 1'b1);
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", s, e, g);
			fails++;
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int i;
		i = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat <= d;
		do begin
			@(posedge clk_i);
			i++;
		end while (ack_o !== 1'b1 && i < 20);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (i >= 20) begin
			fails++;
			final_report();
		end
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e,
		input string s);
		wb(1'b0, a, 32'h0, 4'hF);
		chk(s, e, q);
	endtask
	task automatic pulse(input logic [3:0] m, input logic w);
		ev <= m;
		wd <= w;
		@(posedge clk_i);
		ev <= 4'h0;
		wd <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic t_flags();
		logic [31:0] e;
		e = 32'h0;
		rd(4'h1, 32'h0, "unmapped");
		for (int i = 0; i < 4; i++) begin
			pulse(4'(1 << i), 1'b0);
			e[i] = 1'b1;
			rd(rsf_pkg::OFF_FLAGS, e, "flags");
		end
		wb(1'b1, rsf_pkg::OFF_FLAGS, 32'hFF, 4'hF);
		rd(rsf_pkg::OFF_FLAGS, 32'h0F, "flags");
		wb(1'b1, rsf_pkg::OFF_FLAGS, 32'h0B, 4'hF);
		rd(rsf_pkg::OFF_FLAGS, 32'h0B, "flags");
		wb(1'b1, rsf_pkg::OFF_FLAGS, 32'h00, 4'hF);
		wb(1'b1, rsf_pkg::OFF_FLAGS, 32'h0F, 4'hF);
		rd(rsf_pkg::OFF_FLAGS, 32'h00, "flags");
	endtask
	task automatic t_irq();
		rd(rsf_pkg::OFF_IRQ_STAT, 32'h0F, "status");
		chk("irq", 32'h0, {31'h0, irq_o});
		wb(1'b1, rsf_pkg::OFF_IRQ_MASK, 32'h04, 4'hF);
		repeat (2) @(posedge clk_i);
		chk("irq", 32'h1, {31'h0, irq_o});
		wb(1'b1, rsf_pkg::OFF_IRQ_STAT, 32'h0F, 4'hF);
		rd(rsf_pkg::OFF_IRQ_STAT, 32'h00, "status");
		chk("irq", 32'h0, {31'h0, irq_o});
	endtask
	task automatic t_wdt();
		pulse(4'h4, 1'b1);
		chk("timeout", 32'h1, {31'h0, to_o});
		chk("powerdown", 32'h0, {31'h0, pd_o});
		lp <= 1'b1;
		pulse(4'h0, 1'b1);
		lp <= 1'b0;
		chk("powerdown", 32'h1, {31'h0, pd_o});
		rd(rsf_pkg::OFF_FLAGS, 32'h04, "flags");
		chk("warm", 32'h1, n_warm);
		chk("device reset", 32'h0, n_dev);
	endtask
	task automatic t_key();
		wb(1'b1, rsf_pkg::OFF_FLASH_CTRL, 32'h12, 4'hF);
		wb(1'b1, rsf_pkg::OFF_FLASH_CTRL, 32'h55, 4'hE);
		rd(rsf_pkg::OFF_FLASH_CTRL, 32'h12, "flash ctrl");
		wb(1'b1, rsf_pkg::OFF_FLASH_CTRL, 32'h55, 4'hF);
		repeat (6) @(posedge clk_i);
		chk("device reset", rsf_pkg::DEV_RST_CYCLES, n_dev);
		rd(rsf_pkg::OFF_FLASH_CTRL, 32'h00, "flash ctrl");
		// Low supply, timeout and key events since the status was cleared
		rd(rsf_pkg::OFF_IRQ_STAT, 32'h34, "status");
		chk("irq", 32'h1, {31'h0, irq_o});
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_flags();
		t_irq();
		t_wdt();
		t_key();
		final_report();
	end
endmodule
`default_nettype wire
